/* rtl/boost_pkg.sv */
// constants and types for the boost converter pwm regulator
//
// Summary of operation
// - drive switches at nominal 2.5 MHz unless low frequency is selected
// - a second low-frequency mode switches at nominal 470 kHz
// - frequency select is one bit: 0 gives 2.5 MHz, 1 gives 470 kHz
// - duty cycle is regulated automatically to keep the rail in range
// - period has 22 slots; mark adjustable in whole slots from 1 to 19
// - at light load, if minimum mark is still too high, skip whole pulses
// - regulator runs only while boost_disable is zero, else drive stays low
// - boost_target_level is the regulation setpoint for the rail
// - drive is high during mark, low during space
package boost_pkg;

    // system clock rate
    localparam int unsigned CLK_HZ       = 25_000_000;

    // nominal switching rates
    localparam int unsigned HI_FREQ_HZ   = 2_500_000;
    localparam int unsigned LO_FREQ_HZ   = 470_000;

    // period slot layout
    localparam int unsigned PERIOD_SLOTS = 22;
    localparam int unsigned SLOT_W       = 5;
    localparam logic [4:0]  MARK_MIN     = 5'h01;
    localparam logic [4:0]  MARK_MAX     = 5'h13;
    localparam logic [4:0]  LAST_SLOT    = 5'h15;
    localparam logic [4:0]  MARK_RESET   = MARK_MIN;

    // clocks per slot, rounded down, never below one
    localparam int unsigned HI_SLOT_RAW  = CLK_HZ / (HI_FREQ_HZ * PERIOD_SLOTS);
    localparam int unsigned LO_SLOT_RAW  = CLK_HZ / (LO_FREQ_HZ * PERIOD_SLOTS);
    localparam int unsigned HI_SLOT_CYC  = (HI_SLOT_RAW < 1) ? 1 : HI_SLOT_RAW;
    localparam int unsigned LO_SLOT_CYC  = (LO_SLOT_RAW < 1) ? 1 : LO_SLOT_RAW;

    // rail measurement width
    localparam int unsigned SAMPLE_W     = 8;

    // frequency select encoding
    localparam logic        FREQ_HI      = 1'b0;
    localparam logic        FREQ_LO      = 1'b1;

    typedef logic [4:0] slot_t;

    // per-period regulation decision
    typedef enum logic [1:0] {
        ACT_HOLD,
        ACT_RAISE,
        ACT_LOWER
    } reg_action_t;

endpackage : boost_pkg

/* rtl/boost_pwm_regulator.sv */
// boost converter switch drive with slot-based duty regulation
`timescale 1ns/1ps
module boost_pwm_regulator
#(
    parameter int unsigned SAMPLE_W = boost_pkg::SAMPLE_W
)
(
    // clock and reset
    input  wire logic                clock_i,
    input  wire logic                resetn_i,
    // rail voltage settings
    input  wire logic                boost_disable_i,
    input  wire logic                boost_low_freq_select_i,
    input  wire logic [SAMPLE_W-1:0] boost_target_level_i,
    // measured rail level, same clock domain
    input  wire logic [SAMPLE_W-1:0] rail_sample_i,
    // switch drive to external transistor
    output logic                     boost_switch_drive_o,
    // status
    output boost_pkg::slot_t         mark_slots_o,
    output logic                     pulse_skip_o,
    output logic                     period_end_o
);
    import boost_pkg::*;

    initial
    begin
        if (SAMPLE_W < 1 || MARK_MAX >= LAST_SLOT || MARK_MIN < 5'h01)
            $error("unsupported regulator configuration");
    end

    ////////////////////////////////////////////////////////////////////////
    // slot timing

    logic   run;
    logic   slot_tick;
    logic   freq_q;
    logic   freq_d;
    slot_t  slot_q;
    slot_t  slot_d;
    logic   period_end;

    assign run = !boost_disable_i;

    slot_divider
    #(
        .HI_CYC (HI_SLOT_CYC),
        .LO_CYC (LO_SLOT_CYC)
    )
    u_divider
    (
        .clock_i     (clock_i),
        .resetn_i    (resetn_i),
        .run_i       (run),
        .low_freq_i  (freq_d), // next period's rate sizes its first slot
        .slot_tick_o (slot_tick)
    );

    assign period_end = slot_tick && (slot_q == LAST_SLOT);

    // slot index walks 0..21; frequency only retimed between periods
    always_comb
    begin
        slot_d = slot_q;
        freq_d = freq_q;
        if (!run)
        begin
            slot_d = '0;
            freq_d = boost_low_freq_select_i;
        end
        else if (period_end)
        begin
            slot_d = '0;
            freq_d = boost_low_freq_select_i;
        end
        else if (slot_tick)
        begin
            slot_d = slot_q + 5'h01;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            slot_q <= '0;
            freq_q <= FREQ_HI;
        end
        else
        begin
            slot_q <= slot_d;
            freq_q <= freq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // regulation: one decision per period

    reg_action_t action;
    slot_t       mark_q;
    slot_t       mark_d;
    logic        skip_q;
    logic        skip_d;

    // compare once at the boundary so a mid-period glitch cannot cut a pulse
    always_comb
    begin
        if (rail_sample_i > boost_target_level_i)
            action = ACT_LOWER;
        else if (rail_sample_i < boost_target_level_i)
            action = ACT_RAISE;
        else
            action = ACT_HOLD;
    end

    // one slot step per period trades settling speed for low ripple
    always_comb
    begin
        mark_d = mark_q;
        skip_d = skip_q;
        if (!run)
        begin
            mark_d = MARK_RESET;
            skip_d = 1'b0;
        end
        else if (period_end)
        begin
            unique case (action)
                ACT_LOWER:
                begin
                    if (mark_q > MARK_MIN)
                        mark_d = mark_q - 5'h01;
                    else
                        skip_d = 1'b1;
                end
                ACT_RAISE:
                begin
                    if (skip_q)
                        skip_d = 1'b0;
                    else if (mark_q < MARK_MAX)
                        mark_d = mark_q + 5'h01;
                end
                ACT_HOLD:
                begin
                    mark_d = mark_q;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            mark_q <= MARK_RESET;
            skip_q <= 1'b0;
        end
        else
        begin
            mark_q <= mark_d;
            skip_q <= skip_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // switch drive, registered to keep the gate edge glitch free

    logic drive_q;
    logic drive_d;
    logic pend_q;
    logic pend_d;

    always_comb
    begin
        drive_d = run && !skip_q && (slot_q < mark_q);
        pend_d  = period_end;
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            drive_q <= 1'b0;
            pend_q  <= 1'b0;
        end
        else
        begin
            drive_q <= drive_d;
            pend_q  <= pend_d;
        end
    end

    assign boost_switch_drive_o = drive_q;
    assign mark_slots_o         = mark_q;
    assign pulse_skip_o         = skip_q;
    assign period_end_o         = pend_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    // helper: mark clocks counted over one whole period
    localparam int unsigned HC_W = 12;
    logic [HC_W-1:0] hi_cnt_q;
    logic [HC_W-1:0] hi_cnt_d;
    logic            full_q;
    logic            full_d;
    logic [HC_W-1:0] hi_exp;
    logic [HC_W-1:0] hi_tot;

    always_comb
    begin
        hi_exp = skip_q ? '0
               : HC_W'(mark_q) * (freq_q ? HC_W'(LO_SLOT_CYC)
                                         : HC_W'(HI_SLOT_CYC));
        hi_tot = hi_cnt_q + HC_W'(drive_d);
        hi_cnt_d = hi_cnt_q;
        full_d   = full_q;
        if (!run || period_end)
        begin
            hi_cnt_d = '0;
            full_d   = run;
        end
        else if (drive_d)
            hi_cnt_d = hi_tot;
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            hi_cnt_q <= '0;
            full_q   <= 1'b0;
        end
        else
        begin
            hi_cnt_q <= hi_cnt_d;
            full_q   <= full_d;
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    disabled_drive_low_a: assert property (
        boost_disable_i |=> !boost_switch_drive_o)
        else $error("drive active while boost disabled");

    mark_in_range_a: assert property (
        mark_q >= MARK_MIN && mark_q <= MARK_MAX)
        else $error("mark outside 1..19 slots");

    mark_per_period_a: assert property (
        full_q && period_end |-> hi_tot == hi_exp)
        else $error("mark length in period does not match setting");

    skip_only_min_a: assert property (
        skip_q |-> mark_q == MARK_MIN)
        else $error("pulse skipped above minimum mark");

    mark_boundary_a: assert property (
        run && !period_end |=> $stable(mark_q) && $stable(skip_q))
        else $error("mark changed inside a period");

    raise_step_a: assert property (
        run && period_end && action == ACT_RAISE && !skip_q
        && mark_q < MARK_MAX |=> mark_q == $past(mark_q) + 5'h01)
        else $error("mark not raised on low rail");

    high_at_min_a: assert property (
        run && period_end && action == ACT_LOWER && mark_q == MARK_MIN
        |=> skip_q ##1 !boost_switch_drive_o)
        else $error("no pulse skip on high rail at minimum mark");

    freq_stable_a: assert property (
        run && !period_end |=> $stable(freq_q))
        else $error("frequency changed inside a period");

    slot_bound_a: assert property (
        slot_q <= LAST_SLOT)
        else $error("slot index beyond period");

    skipping_cov: cover property (run && skip_q && period_end);
    max_mark_cov: cover property (run && mark_q == MARK_MAX);
    low_freq_cov: cover property (run && freq_q && period_end);
    reenable_cov: cover property (boost_disable_i ##1 !boost_disable_i);

endmodule : boost_pwm_regulator

/* rtl/slot_divider.sv */
// slot tick divider for the two switching frequencies
`timescale 1ns/1ps
module slot_divider
#(
    parameter int unsigned HI_CYC = 1,
    parameter int unsigned LO_CYC = 2
)
(
    // clock and reset
    input  wire logic clock_i,
    input  wire logic resetn_i,
    // control
    input  wire logic run_i,
    input  wire logic low_freq_i,
    // slot enable pulse
    output logic      slot_tick_o
);
    localparam int unsigned CNT_W = (LO_CYC > HI_CYC) ? $clog2(LO_CYC + 1)
                                                      : $clog2(HI_CYC + 1);
    localparam logic [CNT_W-1:0] HI_LOAD = CNT_W'(HI_CYC - 1);
    localparam logic [CNT_W-1:0] LO_LOAD = CNT_W'(LO_CYC - 1);

    initial
    begin
        if (HI_CYC < 1 || LO_CYC < 1)
            $error("slot divider needs at least one clock per slot");
    end

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    // tick on zero, then reload; idle preloads so slot 0 is full length
    always_comb
    begin
        slot_tick_o = run_i && (cnt_q == '0);
        cnt_d       = low_freq_i ? LO_LOAD : HI_LOAD;
        if (run_i && (cnt_q != '0))
            cnt_d = cnt_q - CNT_W'(1);
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

endmodule : slot_divider

/* verification/boost_pwm_regulator_tb.sv */
// self-checking bench for the boost pwm regulator
`timescale 1ns/1ps
module boost_pwm_regulator_tb;
    import boost_pkg::*;

    logic       clock = 1'b0;
    logic       resetn = 1'b0;
    logic       boost_off = 1'b1;
    logic       low_freq = 1'b0;
    logic       use_model = 1'b0;
    logic [7:0] target = 8'h80;
    logic [7:0] forced = 8'h00;
    logic [7:0] rail_model;
    logic [7:0] rail;
    logic       drive;
    logic       skip;
    logic       pend;
    slot_t      marks;
    int         fail_count = 0;
    int         compares = 0;
    int         exp_mark;
    logic       exp_skip;

    always #20 clock = ~clock;
    // rail comes from the model only in the closed-loop test
    assign rail = use_model ? rail_model : forced;

    boost_pwm_regulator u_boost_pwm_regulator (
        .clock_i(clock), .resetn_i(resetn), .boost_disable_i(boost_off),
        .boost_low_freq_select_i(low_freq), .boost_target_level_i(target),
        .rail_sample_i(rail), .boost_switch_drive_o(drive),
        .mark_slots_o(marks), .pulse_skip_o(skip), .period_end_o(pend));
    boost_rail_model u_boost_rail_model (
        .clock_i(clock), .resetn_i(resetn), .drive_i(drive),
        .rail_o(rail_model));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, exp, input string what);
        compares++;
        if (got !== exp)
        begin
            $display("BAD t=%0t %s got %0h exp %0h", $time, what, got, exp);
            fail_count++;
        end
    endtask : check

    task automatic tally_and_finish();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish

    // bounded wait for the period-end pulse
    task automatic wait_pend();
        for (int i = 0; i < 200; i++)
        begin
            @(negedge clock);
            if (pend === 1'b1)
                return;
        end
        check(32'h0, 32'h1, "period end timeout");
        tally_and_finish();
    endtask : wait_pend

    // reference decision for one period end, from the sample held meanwhile
    task automatic step();
        if (forced < target)
        begin
            if (exp_skip)
                exp_skip = 1'b0;
            else if (exp_mark < 19)
                exp_mark++;
        end
        else if (forced > target)
        begin
            if (exp_mark == 1)
                exp_skip = 1'b1;
            else
                exp_mark--;
        end
    endtask : step

    // restart from disabled; frequency select is taken while disabled
    task automatic enable(input logic lf);
        boost_off = 1'b1;
        low_freq = lf;
        repeat (2) @(negedge clock);
        exp_mark = 1;
        exp_skip = 1'b0;
        check({27'h0, marks}, 32'h1, "mark off");
        check({skip, drive}, 32'h0, "drive off");
        boost_off = 1'b0;
        wait_pend();
        step();
        check({27'h0, marks}, exp_mark, "mark first");
    endtask : enable

    // starts at a period-end pulse; checks length, mark and skip per period
    task automatic run_periods(input int n, cyc, input logic [7:0] samp);
        int len;
        int hi;
        forced = samp;
        for (int k = 0; k < n; k++)
        begin
            len = 0;
            hi = 0;
            do
            begin
                @(negedge clock);
                len++;
                hi += int'(drive);
            end
            while (pend !== 1'b1 && len < 100);
            check(len, 22 * cyc, "period length");
            // a missing period end has been counted above; stop here
            if (pend !== 1'b1)
                tally_and_finish();
            check(hi, exp_skip ? 0 : exp_mark * cyc, "mark cycles");
            step();
            check({27'h0, marks}, exp_mark, "mark");
            check({31'h0, skip}, {31'h0, exp_skip}, "skip");
        end
    endtask : run_periods

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        check({drive, skip, pend}, 32'h0, "reset outputs");
        check({27'h0, marks}, 32'h1, "reset mark");
        $display("test reset done");
    endtask : test_reset

    task automatic test_ramp_and_skip();
        forced = 8'h00;
        enable(1'b0);
        run_periods(20, 1, 8'h00);
        run_periods(20, 1, 8'hff);
        run_periods(2, 1, 8'h00);
        $display("test ramp and skip done");
    endtask : test_ramp_and_skip

    task automatic test_low_freq();
        forced = 8'h00;
        enable(1'b1);
        run_periods(4, 2, 8'h00);
        run_periods(2, 2, 8'h80);
        $display("test low frequency done");
    endtask : test_low_freq

    // rail supplied externally: software holds the regulator off
    task automatic test_disable();
        int act;
        repeat (7) @(negedge clock);
        boost_off = 1'b1;
        act = 0;
        @(negedge clock);
        repeat (60)
        begin
            @(negedge clock);
            act += int'(drive) + int'(pend);
        end
        check(act, 0, "drive while off");
        check({27'h0, marks}, 32'h1, "mark while off");
        $display("test disable done");
    endtask : test_disable

    task automatic test_closed_loop();
        logic lo;
        logic hi;
        logic sat;
        lo = 1'b0;
        hi = 1'b0;
        sat = 1'b0;
        // mid-run reset empties the rail model left charged by earlier tests
        boost_off = 1'b1;
        resetn = 1'b0;
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        test_reset();
        use_model = 1'b1;
        target = 8'h40;
        low_freq = 1'b0;
        boost_off = 1'b0;
        repeat (120)
        begin
            wait_pend();
            lo |= rail_model < target;
            hi |= rail_model > target;
            sat |= rail_model > 8'hf0;
        end
        check({lo, hi, sat}, 32'h6, "rail around target");
        $display("test closed loop done");
    endtask : test_closed_loop

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        test_reset();
        test_ramp_and_skip();
        test_low_freq();
        test_disable();
        test_closed_loop();
        tally_and_finish();
    end
endmodule : boost_pwm_regulator_tb

/* verification/boost_rail_model.sv */
// behavioural boost inductor, diode and output capacitor under load
`timescale 1ns/1ps
module boost_rail_model
(
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    // switch drive from the regulator
    input  wire logic       drive_i,
    // rail level as the regulator samples it
    output logic      [7:0] rail_o
);
    logic [2:0] drain_q;
    logic [2:0] drain_d;
    logic [7:0] rail_d;

    ////////////////////////////////////////////////////////////////////////
    // charge one step per mark cycle, fixed load drains one step on every eighth clock unless that clock charges;
    // crude, but the loop is real and has no damping to hide behind
    always_comb
    begin
        drain_d = drain_q + 3'h1;
        rail_d  = rail_o;
        if (drive_i && rail_o != 8'hff)
            rail_d = rail_o + 8'h01;
        else if (drain_q == 3'h7 && rail_o != 8'h00)
            rail_d = rail_o - 8'h01;
    end

    // state registers
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            drain_q <= 3'h0;
            rail_o  <= 8'h00;
        end
        else
        begin
            drain_q <= drain_d;
            rail_o  <= rail_d;
        end
    end
endmodule : boost_rail_model
